/* pkg/psdc_pkg.sv */
// Shared constants and carrier types for the paged status display control.
// Assumes one system clock with a synchronous, active-high reset.
package psdc_pkg;

    // Display organisation
    localparam int PSDC_PANELS = 2;
    localparam int PSDC_REGS_PER_PANEL = 2;
    localparam int PSDC_NUM_REGS = PSDC_PANELS * PSDC_REGS_PER_PANEL;
    localparam int PSDC_PAGES = 16;
    localparam int PSDC_PAGE_W = 4;
    localparam int PSDC_PAGE_BITS = 128;
    localparam int PSDC_HALF_BITS = 64;
    localparam int PSDC_UPPER_LSB = 64;
    localparam int PSDC_LAMPS_PER_DEV = 4;
    localparam int PSDC_HALF_DEVS = 16;
    localparam int PSDC_DEVICES = 2 * PSDC_HALF_DEVS;
    localparam int PSDC_SEL_DEVS = 1;

    // Field positions of the register-wide buttons (device index = bit / 4)
    localparam int PSDC_LAMP_TEST_DEV = 0 / PSDC_LAMPS_PER_DEV;
    localparam int PSDC_RESET_FN_DEV = 64 / PSDC_LAMPS_PER_DEV;

    // Cycle counts
    localparam int PSDC_SYNC_STAGES = 2;
    localparam int PSDC_ACTION_CYCLES = 1;

    // One page of displayed signals, and the bank of pages of one panel
    typedef logic [PSDC_PAGE_BITS-1:0] psdc_page_type;
    typedef psdc_page_type [PSDC_PAGES-1:0] psdc_bank_type;

    // Operator controls of one display register
    typedef struct packed {
        logic [PSDC_PAGE_W-1:0] page_sel;
        logic [PSDC_PAGE_BITS-1:0] bit_btn;
        logic [PSDC_DEVICES-1:0] fifth_btn;
    } psdc_reg_btn_type;

    // Indicators of one display register
    typedef struct packed {
        logic [PSDC_PAGE_W-1:0] page_shown;
        psdc_page_type lamp;
    } psdc_reg_disp_type;

    // Set and clear strobes toward the flip-flops of one panel
    typedef struct packed {
        psdc_bank_type set_stb;
        psdc_bank_type clr_stb;
    } psdc_action_type;

    // Values after reset
    localparam psdc_reg_disp_type PSDC_DISP_RST = '0;
    localparam psdc_action_type PSDC_ACTION_RST = '0;

endpackage

/* src/psdc_sync.sv */
// Two-flop synchroniser for a vector of panel inputs.
// Assumes the inputs are quasi-static push-buttons and selector levels.
`timescale 1ns/10ps
module psdc_sync
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Raw and synchronised levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import psdc_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } psdc_sync_state_type;

    psdc_sync_state_type state_q;
    psdc_sync_state_type state_d;

    // First stage feeds only the second stage
    always_comb
    begin
        state_d.meta = async_in;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.stable;

endmodule

/* src/psdc_page_mux.sv */
// Page selector: picks one page of signals out of a panel's bank.
// Assumes the bank and page number come from logic on the same clock.
`timescale 1ns/10ps
module psdc_page_mux
(
    // Bank of pages and selection
    input wire psdc_pkg::psdc_bank_type bank,
    input wire logic [psdc_pkg::PSDC_PAGE_W-1:0] page,
    // Chosen page
    output psdc_pkg::psdc_page_type page_bits
);
    import psdc_pkg::*;

    // R1 page selection
    assign page_bits = bank[page];

endmodule

/* src/psdc_top.sv */
// Paged status display control: four display registers on two panels,
// lamps, per-bit set/reset buttons, reset-function and lamp-test/clear.
// Assumes the system flip-flops apply the strobes on the next edge and
// that buttons and selectors arrive as raw pins.
`timescale 1ns/10ps

// Contract
// R1 - Each register shows one of 16 pages of 128 signals.
// R2 - A bit button sets or resets the displayed flip-flop.
// R3 - Both registers of a panel share 16 pages, chosen independently.
// R4 - Each register splits into upper and lower halves of 64 bits.
// R5 - A register is 32 four-bit devices plus one page selector device.
// R6 - Each device has 4 lamps and 5 buttons, one per lamp.
// R7 - Button under bit 64 turns all bit buttons into reset.
// R8 - Holding the button under bit 0 lights every lamp.
// R9 - Releasing that button clears every signal shown by the register.
// R10 - Other fifth buttons are ignored and alter nothing.
// R11 - Lit lamp means set or true; dark means reset or false.
// R12 - Two panels with two registers each, four registers in all.
// R13 - Upper half carries bits 64 to 127, lower half 0 to 63.
// R14 - Button actions are synchronised and applied as one-cycle strobes.
module psdc_top
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // System flip-flop states and strobes, one bank per panel
    input wire psdc_pkg::psdc_bank_type [psdc_pkg::PSDC_PANELS-1:0] sys_state,
    output psdc_pkg::psdc_action_type [psdc_pkg::PSDC_PANELS-1:0] sys_action,
    // Operator panel controls and indicators, one per display register
    input wire psdc_pkg::psdc_reg_btn_type [psdc_pkg::PSDC_NUM_REGS-1:0] btn,
    output psdc_pkg::psdc_reg_disp_type [psdc_pkg::PSDC_NUM_REGS-1:0] disp
);
    import psdc_pkg::*;

    localparam int BTN_W = $bits(psdc_reg_btn_type) * PSDC_NUM_REGS;

    typedef struct packed {
        psdc_reg_btn_type [PSDC_NUM_REGS-1:0] btn_prev;
        psdc_reg_disp_type [PSDC_NUM_REGS-1:0] disp;
        psdc_action_type [PSDC_PANELS-1:0] act;
    } psdc_top_state_type;

    psdc_top_state_type state_q;
    psdc_top_state_type state_d;
    psdc_reg_btn_type [PSDC_NUM_REGS-1:0] btn_s;
    psdc_page_type page_bits [PSDC_NUM_REGS];

    // R14 pin synchroniser
    psdc_sync
    #(
        .WIDTH(BTN_W)
    )
    u_sync
    (
        .clock(clock),
        .srst(srst),
        .async_in(btn),
        .sync_out(btn_s)
    );

    // R12 four registers
    genvar g;
    generate
        for (g = 0; g < PSDC_NUM_REGS; g++)
        begin : gen_reg
            // R3 panel-shared bank
            psdc_page_mux u_mux
            (
                .bank(sys_state[g / PSDC_REGS_PER_PANEL]),
                .page(btn_s[g].page_sel),
                .page_bits(page_bits[g])
            );
        end
    endgenerate

    always_comb
    begin
        int p;
        logic [PSDC_PAGE_W-1:0] pg;
        logic [PSDC_PAGE_BITS-1:0] rise;
        logic lt_held;
        logic lt_rel;
        logic rst_fn;
        p = 0;
        pg = '0;
        rise = '0;
        lt_held = 1'b0;
        lt_rel = 1'b0;
        rst_fn = 1'b0;
        state_d = state_q;
        state_d.btn_prev = btn_s;
        // R14 strobes last one cycle
        state_d.act = PSDC_ACTION_RST;
        for (int r = 0; r < PSDC_NUM_REGS; r++)
        begin
            p = r / PSDC_REGS_PER_PANEL;
            pg = btn_s[r].page_sel;
            // R6 one button per lamp, edge-detected
            rise = btn_s[r].bit_btn & ~state_q.btn_prev[r].bit_btn;
            // R10 only two fifth buttons are decoded
            lt_held = btn_s[r].fifth_btn[PSDC_LAMP_TEST_DEV];
            lt_rel = state_q.btn_prev[r].fifth_btn[PSDC_LAMP_TEST_DEV] & ~lt_held;
            rst_fn = btn_s[r].fifth_btn[PSDC_RESET_FN_DEV];
            if (lt_rel)
            begin
                // R9 clear whole shown page
                state_d.act[p].clr_stb[pg] = '1;
            end
            else if (rst_fn)
            begin
                // R7 reset-function select
                state_d.act[p].clr_stb[pg] = state_d.act[p].clr_stb[pg] | rise;
            end
            else
            begin
                // R2 set action
                state_d.act[p].set_stb[pg] = state_d.act[p].set_stb[pg] | rise;
            end
            // R5 selector device shown
            state_d.disp[r].page_shown = pg;
            if (lt_held)
            begin
                // R8 lamp test
                state_d.disp[r].lamp = '1;
            end
            else
            begin
                // R4 R13 both halves copied
                // R11 lamp shows state
                state_d.disp[r].lamp = page_bits[r];
            end
        end
        // Two registers of a panel may hit one bit at once; clearing wins
        for (int q = 0; q < PSDC_PANELS; q++)
        begin
            for (int n = 0; n < PSDC_PAGES; n++)
            begin
                state_d.act[q].set_stb[n] = state_d.act[q].set_stb[n] & ~state_d.act[q].clr_stb[n];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign sys_action = state_q.act;
    assign disp = state_q.disp;

    // Lamps all lit one cycle after lamp test is seen
    property p_lamp_test;
        @(posedge clock) disable iff (srst)
        btn_s[0].fifth_btn[PSDC_LAMP_TEST_DEV] |=> disp[0].lamp == '1;
    endproperty
    a_lamp_test: assert property (p_lamp_test) // R8
        else $error("lamp test did not light every lamp");

    // A held lamp test keeps the register fully lit
    property p_lamp_test_hold;
        @(posedge clock) disable iff (srst)
        btn_s[3].fifth_btn[PSDC_LAMP_TEST_DEV] [*3] |=> disp[3].lamp == '1;
    endproperty
    a_lamp_test_hold: assert property (p_lamp_test_hold) // R8
        else $error("lamp went dark during held lamp test");

    // Lamps follow the selected page of the panel bank
    property p_lamp_follow;
        @(posedge clock) disable iff (srst)
        !btn_s[1].fifth_btn[PSDC_LAMP_TEST_DEV] |=> disp[1].lamp == $past(sys_state[0][btn_s[1].page_sel]);
    endproperty
    a_lamp_follow: assert property (p_lamp_follow) // R11
        else $error("lamps differ from selected page");

    // Upper half carries bits 64 to 127 of the page
    property p_upper_half;
        @(posedge clock) disable iff (srst)
        !btn_s[2].fifth_btn[PSDC_LAMP_TEST_DEV]
        |=> disp[2].lamp[PSDC_PAGE_BITS-1:PSDC_UPPER_LSB] ==
            $past(sys_state[1][btn_s[2].page_sel][PSDC_PAGE_BITS-1:PSDC_UPPER_LSB]);
    endproperty
    a_upper_half: assert property (p_upper_half) // R13
        else $error("upper half shows wrong bits");

    // Same page on both registers of a panel gives the same lamps
    property p_shared_pages;
        @(posedge clock) disable iff (srst)
        (btn_s[2].page_sel == btn_s[3].page_sel && !btn_s[2].fifth_btn[PSDC_LAMP_TEST_DEV]
            && !btn_s[3].fifth_btn[PSDC_LAMP_TEST_DEV])
        |=> disp[2].lamp == disp[3].lamp && disp[2].page_shown == disp[3].page_shown;
    endproperty
    a_shared_pages: assert property (p_shared_pages) // R3
        else $error("registers of one panel disagree on a page");

    // Releasing lamp test clears the whole shown page for one cycle
    property p_clear_on_release;
        @(posedge clock) disable iff (srst)
        $fell(btn_s[0].fifth_btn[PSDC_LAMP_TEST_DEV])
        |=> sys_action[0].clr_stb[$past(btn_s[0].page_sel)] == '1;
    endproperty
    a_clear_on_release: assert property (p_clear_on_release) // R9
        else $error("release of lamp test did not clear the page");

    // Reset function turns a bit press into a clear
    property p_reset_fn;
        @(posedge clock) disable iff (srst)
        ($rose(btn_s[1].bit_btn[5]) && btn_s[1].fifth_btn[PSDC_RESET_FN_DEV])
        |=> sys_action[0].clr_stb[$past(btn_s[1].page_sel)][5] && !sys_action[0].set_stb[$past(btn_s[1].page_sel)][5];
    endproperty
    a_reset_fn: assert property (p_reset_fn) // R7
        else $error("reset function press did not clear the bit");

    // A plain bit press acts on its flip-flop
    property p_bit_press;
        @(posedge clock) disable iff (srst)
        $rose(btn_s[3].bit_btn[70])
        |=> sys_action[1].set_stb[$past(btn_s[3].page_sel)][70] || sys_action[1].clr_stb[$past(btn_s[3].page_sel)][70];
    endproperty
    a_bit_press: assert property (p_bit_press) // R2
        else $error("bit press produced no strobe");

    // A held button strobes once, never set and clear together
    property p_single_strobe;
        @(posedge clock) disable iff (srst)
        (sys_action[0].set_stb != '0) |=> (sys_action[0].set_stb & $past(sys_action[0].set_stb)) == '0
            && (sys_action[0].set_stb & sys_action[0].clr_stb) == '0;
    endproperty
    a_single_strobe: assert property (p_single_strobe) // R14
        else $error("strobe lasted longer than one cycle");

    // Without a press or a release nothing on the panel is touched
    property p_quiet_panel;
        @(posedge clock) disable iff (srst)
        ((btn_s[0].bit_btn & ~$past(btn_s[0].bit_btn)) == '0
            && (btn_s[1].bit_btn & ~$past(btn_s[1].bit_btn)) == '0
            && !$fell(btn_s[0].fifth_btn[PSDC_LAMP_TEST_DEV])
            && !$fell(btn_s[1].fifth_btn[PSDC_LAMP_TEST_DEV]))
        |=> sys_action[0] == '0;
    endproperty
    a_quiet_panel: assert property (p_quiet_panel) // R10
        else $error("strobe without a decoded button");

    // Selector device reports the synchronised page one cycle later
    property p_page_shown;
        @(posedge clock) disable iff (srst)
        disp[0].page_shown == $past(btn_s[0].page_sel);
    endproperty
    a_page_shown: assert property (p_page_shown) // R5
        else $error("page selector shows the wrong page");

    // Lower half carries bits 0 to 63 of the page
    property p_lower_half;
        @(posedge clock) disable iff (srst)
        !btn_s[0].fifth_btn[PSDC_LAMP_TEST_DEV]
        |=> disp[0].lamp[PSDC_HALF_BITS-1:0] == $past(sys_state[0][btn_s[0].page_sel][PSDC_HALF_BITS-1:0]);
    endproperty
    a_lower_half: assert property (p_lower_half) // R4
        else $error("lower half shows wrong bits");

    // Registers of the second panel draw from the second bank
    property p_panel_two_follow;
        @(posedge clock) disable iff (srst)
        !btn_s[3].fifth_btn[PSDC_LAMP_TEST_DEV] |=> disp[3].lamp == $past(sys_state[1][btn_s[3].page_sel]);
    endproperty
    a_panel_two_follow: assert property (p_panel_two_follow) // R12
        else $error("second panel lamps differ from its bank");

    // Lamp test lights the second panel as well
    property p_lamp_test_panel_two;
        @(posedge clock) disable iff (srst)
        btn_s[2].fifth_btn[PSDC_LAMP_TEST_DEV] |=> disp[2].lamp == '1;
    endproperty
    a_lamp_test_panel_two: assert property (p_lamp_test_panel_two) // R8
        else $error("lamp test did not light the second panel");

    // Release on the second panel clears its shown page
    property p_clear_panel_two;
        @(posedge clock) disable iff (srst)
        $fell(btn_s[3].fifth_btn[PSDC_LAMP_TEST_DEV])
        |=> sys_action[1].clr_stb[$past(btn_s[3].page_sel)] == '1;
    endproperty
    a_clear_panel_two: assert property (p_clear_panel_two) // R9
        else $error("release of lamp test did not clear the second panel page");

    // A held button gives no second set while its partner stays quiet
    property p_held_no_repeat;
        @(posedge clock) disable iff (srst)
        (btn_s[0].bit_btn[77] && $past(btn_s[0].bit_btn[77]) && !$rose(btn_s[1].bit_btn[77]))
        |=> !sys_action[0].set_stb[$past(btn_s[0].page_sel)][77];
    endproperty
    a_held_no_repeat: assert property (p_held_no_repeat) // R14
        else $error("held button strobed again");

    // Second panel is untouched without a press or a release
    property p_quiet_panel_two;
        @(posedge clock) disable iff (srst)
        ((btn_s[2].bit_btn & ~$past(btn_s[2].bit_btn)) == '0
            && (btn_s[3].bit_btn & ~$past(btn_s[3].bit_btn)) == '0
            && !$fell(btn_s[2].fifth_btn[PSDC_LAMP_TEST_DEV])
            && !$fell(btn_s[3].fifth_btn[PSDC_LAMP_TEST_DEV]))
        |=> sys_action[1] == '0;
    endproperty
    a_quiet_panel_two: assert property (p_quiet_panel_two) // R10
        else $error("second panel strobe without a decoded button");

endmodule

/* testbench/psdc_sys_model.sv */
// Model of the system flip-flops behind both panels.
// Assumes strobes from the display logic land on the next rising edge.
`timescale 1ns/10ps
module psdc_sys_model
(
    // Clock
    input wire logic clock,
    // Preload of every page from the bench
    input wire logic load,
    input wire psdc_pkg::psdc_bank_type [psdc_pkg::PSDC_PANELS-1:0] load_val,
    // Strobes in, flip-flop states out
    input wire psdc_pkg::psdc_action_type [psdc_pkg::PSDC_PANELS-1:0] sys_action,
    output psdc_pkg::psdc_bank_type [psdc_pkg::PSDC_PANELS-1:0] sys_state
);
    import psdc_pkg::*;

    // Clear is applied after set, so a clash leaves the bit reset
    always_ff @(posedge clock)
    begin
        if (load)
            sys_state <= load_val;
        else
            for (int p = 0; p < PSDC_PANELS; p++)
                sys_state[p] <= (sys_state[p] | sys_action[p].set_stb) & ~sys_action[p].clr_stb;
    end
endmodule

/* testbench/psdc_top_tb.sv */
// Self-checking bench for the paged status display control.
// Assumes the flip-flop model above and inputs driven at falling edges.
`timescale 1ns/10ps
module psdc_top_tb;
    import psdc_pkg::*;
    logic clock;
    logic srst;
    logic load;
    psdc_bank_type [PSDC_PANELS-1:0] load_val;
    psdc_bank_type [PSDC_PANELS-1:0] sys_state;
    psdc_action_type [PSDC_PANELS-1:0] sys_action;
    psdc_reg_btn_type [PSDC_NUM_REGS-1:0] btn;
    psdc_reg_disp_type [PSDC_NUM_REGS-1:0] disp;
    logic [127:0] model_st [PSDC_PANELS][PSDC_PAGES];
    int pg [PSDC_NUM_REGS];
    int err_total;
    int n_tests;

    psdc_top dut (.clock(clock), .srst(srst), .sys_state(sys_state), .sys_action(sys_action),
        .btn(btn), .disp(disp));
    psdc_sys_model sys (.clock(clock), .load(load), .load_val(load_val), .sys_action(sys_action),
        .sys_state(sys_state));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check_all();
        for (int r = 0; r < PSDC_NUM_REGS; r++)
        begin
            chk(disp[r].lamp, model_st[r/2][pg[r]]);
            chk(128'(disp[r].page_shown), 128'(pg[r]));
        end
        for (int p = 0; p < PSDC_PANELS; p++)
            for (int g = 0; g < PSDC_PAGES; g++)
                chk(sys_state[p][g], model_st[p][g]);
    endtask

    task automatic pick(input int r, input int g);
        pg[r] = g;
        btn[r].page_sel = 4'(g);
    endtask

    // Press one bit button, optionally with the reset-function button held
    task automatic hit(input int r, input int b, input bit rfn);
        repeat (4) @(negedge clock);
        btn[r].fifth_btn[16] = rfn;
        btn[r].bit_btn[b] = 1'b1;
        repeat (6) @(negedge clock);
        btn[r].bit_btn[b] = 1'b0;
        btn[r].fifth_btn[16] = 1'b0;
        repeat (4) @(negedge clock);
        model_st[r/2][pg[r]][b] = !rfn;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        void'($urandom(1));
        srst = 1'b1;
        load = 1'b1;
        btn = '0;
        for (int p = 0; p < PSDC_PANELS; p++)
            for (int g = 0; g < PSDC_PAGES; g++)
            begin
                model_st[p][g] = {$urandom, $urandom, $urandom, $urandom};
                load_val[p][g] = model_st[p][g];
            end
        for (int r = 0; r < PSDC_NUM_REGS; r++)
            pg[r] = 0;
        repeat (16) @(negedge clock);
        srst = 1'b0;
        load = 1'b0;
        // Independent pages per register, boundaries first, then shared pages
        for (int it = 0; it < 8; it++)
        begin
            for (int r = 0; r < PSDC_NUM_REGS; r++)
                pick(r, it == 0 ? r * 5 : (it == 3 && r % 2 == 1) ? pg[r - 1] : int'($urandom_range(15)));
            repeat (6) @(negedge clock);
            check_all();
        end
        $display("test paging done");
        for (int k = 0; k < 12; k++)
        begin
            int r;
            r = $urandom_range(3);
            pick(r, $urandom_range(15));
            hit(r, k < 4 ? (k * 127) / 3 : int'($urandom_range(127)), k < 4 ? k[0] : 1'($urandom_range(1)));
            check_all();
        end
        $display("test set and reset done");
        // Set and clear of one bit from both registers of a panel at once
        pick(1, pg[0]);
        hit(0, 77, 1'b0);
        btn[0].bit_btn[77] = 1'b1;
        btn[1].fifth_btn[16] = 1'b1;
        btn[1].bit_btn[77] = 1'b1;
        repeat (6) @(negedge clock);
        btn[0].bit_btn[77] = 1'b0;
        btn[1].bit_btn[77] = 1'b0;
        btn[1].fifth_btn[16] = 1'b0;
        repeat (4) @(negedge clock);
        model_st[0][pg[0]][77] = 1'b0;
        check_all();
        $display("test clash done");
        for (int r = 0; r < PSDC_NUM_REGS; r++)
        begin
            btn[r].fifth_btn[0] = 1'b1;
            repeat (5) @(negedge clock);
            chk(disp[r].lamp, '1);
            btn[r].fifth_btn[0] = 1'b0;
            repeat (6) @(negedge clock);
            model_st[r/2][pg[r]] = '0;
            check_all();
        end
        $display("test lamp test done");
        // Unused fifth buttons held during a press must not turn it into reset
        for (int r = 0; r < PSDC_NUM_REGS; r++)
        begin
            btn[r].fifth_btn = $urandom & 32'hFFFE_FFFE;
            hit(r, $urandom_range(127), 1'b0);
            btn[r].fifth_btn = '0;
            repeat (4) @(negedge clock);
            check_all();
        end
        $display("test unused buttons done");
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("BAD t=%0t run did not finish", $time);
        conclude();
    end
endmodule
